// File: hdl/coulomb_accumulator.v
`timescale 1ns/1ps
`include "coulomb_regs.vh"


module coulomb_accumulator #(
  parameter [31:0] ACR_WINDOW_CYCLES = `ACR_WINDOW_CYCLES,
  // Factory calibration value, arbitrary default
  parameter [15:0] FACTORY_GAIN = `FACTORY_GAIN_DEFAULT
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output wire [31:0] readdata,
  output wire waitrequest,
  input wire adc_valid,
  input wire [15:0] adc_sample,
  output wire adc_offset_conv,
  input wire [15:0] temp_value,
  input wire [15:0] nv_charge_in,
  input wire [15:0] nv_gain_in,
  input wire [7:0] nv_tc_in,
  output wire nv_charge_store,
  output wire [15:0] nv_charge_out,
  output wire nv_param_store,
  output wire [15:0] nv_gain_out,
  output wire [7:0] nv_tc_out
);

  localparam [29:0] ACC_MAX = {2'b00, 28'hFFF_FFFF};

  function [15:0] sat16;
    input signed [16:0] v;
    begin
      if (v > 17'sh0_7FFF) begin
        sat16 = 16'h7FFF;
      end else if (v < -17'sh0_8000) begin
        sat16 = 16'h8000;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] upd;
    input [1:0] be;
    begin
      merge16 = {be[1] ? upd[15:8] : old[15:8], be[0] ? upd[7:0] : old[7:0]};
    end
  endfunction

  // Saturating add of a signed current into the unsigned charge
  function [27:0] acc_add;
    input [27:0] acc;
    input signed [15:0] cur;
    reg signed [29:0] sum;
    begin
      sum = $signed({2'b00, acc}) + {{14{cur[15]}}, cur};
      if (sum < 30'sh0000_0000) begin
        acc_add = 28'h000_0000;
      end else if (sum > $signed(ACC_MAX)) begin
        acc_add = 28'hFFF_FFFF;
      end else begin
        acc_add = sum[27:0];
      end
    end
  endfunction

  reg ack_reg;
  reg [31:0] readdata_reg;
  reg [7:0] bias_reg;
  reg [10:0] gain_reg;
  reg [7:0] tc_reg;
  reg control_reg;
  reg [15:0] current_reg;
  reg repeat_ok_reg;
  reg [15:0] offset_corr_reg;
  reg [9:0] conv_index_reg;
  reg [27:0] acc_reg;
  reg [27:0] acc_next;
  reg skip_reg;
  reg [7:0] hi_stage_reg;
  reg hi_valid_reg;
  reg [31:0] window_cnt_reg;
  reg [9:0] backup_cnt_reg;
  reg nv_store_reg;
  reg param_store_reg;
  reg nv_loaded_reg;

  wire [15:0] corr_result;
  wire corr_allowed;

  wire wr_take = write && ack_reg;
  wire rd_start = read && !ack_reg;
  wire offset_now = (conv_index_reg == `OFFSET_SLOT);
  wire [15:0] raw_corrected = sat16($signed({adc_sample[15], adc_sample}) -
                                   $signed({offset_corr_reg[15], offset_corr_reg}));

  // Avalon slave: one wait state on every access
  assign waitrequest = (read || write) && !ack_reg;
  assign readdata = readdata_reg;
  assign adc_offset_conv = offset_now;
  assign nv_charge_store = nv_store_reg;
  assign nv_charge_out = acc_reg[27:`FRAC_BITS];
  assign nv_param_store = param_store_reg;
  assign nv_gain_out = {5'b00000, gain_reg};
  assign nv_tc_out = tc_reg;

  current_correct corr (
    .mclk(mclk),
    .rst(rst),
    .raw(raw_corrected),
    .gain(gain_reg),
    .temp_coef(tc_reg),
    .temp(temp_value),
    .bias(bias_reg),
    .dblank_en(control_reg),
    .result(corr_result),
    .accum_allowed(corr_allowed)
  );

  // Charge write decode: both lanes at once, or high lane staged then low lane
  wire charge_sel = wr_take && (address == `OFS_CHARGE);
  wire hi_only = charge_sel && byteenable[1] && !byteenable[0];
  wire commit_both = charge_sel && byteenable[1] && byteenable[0];
  wire commit_low = charge_sel && byteenable[0] && !byteenable[1] && hi_valid_reg;
  wire charge_commit = commit_both || commit_low;
  wire [15:0] charge_value = commit_both ? writedata[15:0] : {hi_stage_reg, writedata[7:0]};
  wire window_end = hi_valid_reg && (window_cnt_reg == ACR_WINDOW_CYCLES - 32'h0000_0001);
  wire [15:0] gain_merged = merge16({5'b00000, gain_reg}, writedata[15:0], byteenable[1:0]);

  always @(posedge mclk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= (read || write) && !ack_reg;
      if (rd_start) begin
        if (address == `OFS_CURRENT) begin
          readdata_reg <= {16'h0000, current_reg};
        end else if (address == `OFS_BIAS) begin
          readdata_reg <= {24'h00_0000, bias_reg};
        end else if (address == `OFS_GAIN) begin
          readdata_reg <= {21'h00_0000, gain_reg};
        end else if (address == `OFS_TC) begin
          readdata_reg <= {24'h00_0000, tc_reg};
        end else if (address == `OFS_CHARGE) begin
          readdata_reg <= {16'h0000, acc_reg[27:`FRAC_BITS]};
        end else if (address == `OFS_CONTROL) begin
          readdata_reg <= {31'h0000_0000, control_reg};
        end else if (address == `OFS_STATUS) begin
          readdata_reg <= {20'h0_0000, conv_index_reg, skip_reg, hi_valid_reg};
        end else if (address == `OFS_OFFSET) begin
          readdata_reg <= {16'h0000, offset_corr_reg};
        end else if (address == `OFS_FACTORY) begin
          readdata_reg <= {16'h0000, FACTORY_GAIN};
        end else begin
          readdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // Settings registers; gain and coefficient come back from the backup store
  always @(posedge mclk) begin
    if (rst) begin
      bias_reg <= `BIAS_RESET;
      gain_reg <= `GAIN_RESET;
      tc_reg <= `TC_RESET;
      control_reg <= `CONTROL_RESET;
      param_store_reg <= 1'b0;
    end else begin
      param_store_reg <= 1'b0;
      if (!nv_loaded_reg) begin
        gain_reg <= nv_gain_in[10:0];
        tc_reg <= nv_tc_in;
      end else if (wr_take) begin
        if (address == `OFS_BIAS && byteenable[0]) begin
          bias_reg <= writedata[7:0];
        end else if (address == `OFS_GAIN && byteenable[1:0] != 2'b00) begin
          gain_reg <= gain_merged[10:0];
          param_store_reg <= 1'b1;
        end else if (address == `OFS_TC && byteenable[0]) begin
          tc_reg <= writedata[7:0];
          param_store_reg <= 1'b1;
        end else if (address == `OFS_CONTROL && byteenable[0]) begin
          control_reg <= writedata[`CTRL_DBLANK_BIT];
        end
      end
    end
  end

  // High byte staging and its write window
  always @(posedge mclk) begin
    if (rst) begin
      hi_stage_reg <= 8'h00;
      hi_valid_reg <= 1'b0;
      window_cnt_reg <= 32'h0000_0000;
    end else begin
      if (hi_only) begin
        hi_stage_reg <= writedata[15:8];
        hi_valid_reg <= 1'b1;
        window_cnt_reg <= 32'h0000_0000;
      end else if (charge_commit || window_end) begin
        // A stale high byte must not pair with a much later low byte
        hi_valid_reg <= 1'b0;
        window_cnt_reg <= 32'h0000_0000;
      end else if (hi_valid_reg) begin
        window_cnt_reg <= window_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Accumulator next value
  always @* begin
    acc_next = acc_reg;
    if (charge_commit) begin
      acc_next = {charge_value, {`FRAC_BITS{1'b0}}};
    end else if (adc_valid && !skip_reg) begin
      // One current LSb per conversion is 2^-12 charge LSb (3.52 s vs 3.5156 s)
      if (offset_now) begin
        if (repeat_ok_reg) begin
          acc_next = acc_add(acc_reg, current_reg);
        end
      end else if (corr_allowed) begin
        acc_next = acc_add(acc_reg, corr_result);
      end
    end
  end

  // Conversion sequencing, offset slot and accumulation
  always @(posedge mclk) begin
    if (rst) begin
      nv_loaded_reg <= 1'b0;
      acc_reg <= 28'h000_0000;
      current_reg <= 16'h0000;
      repeat_ok_reg <= 1'b0;
      offset_corr_reg <= 16'h0000;
      conv_index_reg <= `OFFSET_SLOT;
      skip_reg <= 1'b0;
    end else begin
      nv_loaded_reg <= 1'b1;
      if (!nv_loaded_reg) begin
        acc_reg <= {nv_charge_in, {`FRAC_BITS{1'b0}}};
      end else begin
        acc_reg <= acc_next;
      end
      if (charge_commit) begin
        // The next conversion measures offset, the one after resumes
        conv_index_reg <= `OFFSET_SLOT;
        skip_reg <= 1'b1;
      end else if (adc_valid) begin
        conv_index_reg <= conv_index_reg + 10'h001;
        skip_reg <= 1'b0;
        if (offset_now) begin
          offset_corr_reg <= adc_sample;
        end else begin
          current_reg <= corr_result;
          repeat_ok_reg <= corr_allowed;
        end
      end
    end
  end

  // Periodic backup of the charge register
  always @(posedge mclk) begin
    if (rst) begin
      backup_cnt_reg <= 10'h000;
      nv_store_reg <= 1'b0;
    end else begin
      nv_store_reg <= 1'b0;
      if (adc_valid) begin
        if (backup_cnt_reg == `NV_BACKUP_CONVS - 10'h001) begin
          backup_cnt_reg <= 10'h000;
          nv_store_reg <= 1'b1;
        end else begin
          backup_cnt_reg <= backup_cnt_reg + 10'h001;
        end
      end
    end
  end

endmodule

// File: inc/coulomb_regs.vh
`ifndef COULOMB_REGS_VH
`define COULOMB_REGS_VH

// Register byte offsets
`define OFS_CURRENT 8'h00
`define OFS_BIAS 8'h04
`define OFS_GAIN 8'h08
`define OFS_TC 8'h0C
`define OFS_CHARGE 8'h10
`define OFS_CONTROL 8'h14
`define OFS_STATUS 8'h18
`define OFS_OFFSET 8'h1C
`define OFS_FACTORY 8'hB0

// Field positions
`define CTRL_DBLANK_BIT 0
`define ST_HIGH_STAGED_BIT 0
`define ST_RESUME_BIT 1
`define ST_SLOT_LSB 2
`define ST_SLOT_MSB 11

// Reset values
`define BIAS_RESET 8'h00
`define GAIN_RESET 11'h400
`define TC_RESET 8'h00
`define CONTROL_RESET 1'b0
`define FACTORY_GAIN_DEFAULT 16'h0400

// Blanking thresholds in current LSbs (1.5625 uV each)
`define CHG_BLANK_LSB 16'h0040
`define DIS_BLANK_LSB 16'h0010

// Conversion slot used for the offset measurement, 1 in 1024
`define OFFSET_SLOT 10'h000
`define NV_BACKUP_CONVS 10'h040

// Temperature compensation reference in half degrees (25 C)
`define TC_REF_HALF 15'h0032

// Hidden fraction bits below the charge LSb
`define FRAC_BITS 12

// Charge register two-byte write window
`define ACR_WINDOW_MS 32'h0000_0DAC
`define MCLK_KHZ 32'h0000_9C40
`define ACR_WINDOW_CYCLES (`ACR_WINDOW_MS * `MCLK_KHZ)

`endif

// File: hdl/current_correct.v
`timescale 1ns/1ps
`include "coulomb_regs.vh"

module current_correct (
  input wire mclk,
  input wire rst,
  input wire signed [15:0] raw,
  input wire [10:0] gain,
  input wire [7:0] temp_coef,
  input wire signed [15:0] temp,
  input wire signed [7:0] bias,
  input wire dblank_en,
  output wire signed [15:0] result,
  output wire accum_allowed
);

  reg signed [13:0] temp_half_reg;
  reg signed [23:0] comp_k_reg;

  wire signed [13:0] temp_half = temp[15:2];
  wire signed [14:0] dhalf = {temp_half[13], temp_half} - `TC_REF_HALF;
  wire signed [8:0] tc_s = {1'b0, temp_coef};

  // Compensation factor only moves on half-degree crossings
  always @(posedge mclk) begin
    if (rst) begin
      temp_half_reg <= 14'sh0000;
      comp_k_reg <= 24'sh00_0000;
    end else begin
      temp_half_reg <= temp_half;
      if (temp_half != temp_half_reg) begin
        comp_k_reg <= tc_s * dhalf;
      end
    end
  end

  wire signed [27:0] gain_prod = raw * $signed({1'b0, gain});
  wire signed [17:0] gained = gain_prod[27:10];
  // One step is about 30.5 ppm per degree, so the product is scaled by 2^-16
  wire signed [41:0] adj_prod = gained * comp_k_reg;
  wire signed [25:0] adj = (temp_coef == 8'h00) ? 26'sh000_0000 : adj_prod[41:16];
  wire signed [25:0] comp = {{8{gained[17]}}, gained} - adj;
  wire signed [25:0] biased = comp + {{18{bias[7]}}, bias};

  assign result = (biased > 26'sh000_7FFF) ? 16'sh7FFF :
                  (biased < -26'sh000_8000) ? 16'sh8000 : biased[15:0];

  wire chg_blank = (result > 16'sh0000) && (result < $signed(`CHG_BLANK_LSB));
  wire dis_blank = dblank_en && (result < 16'sh0000) &&
                   (result > -$signed(`DIS_BLANK_LSB));
  assign accum_allowed = !chg_blank && !dis_blank;

endmodule

// File: verification/coulomb_checker.sv
`timescale 1ns/1ps
`include "coulomb_regs.vh"
module coulomb_checker #(
  parameter [15:0] FACTORY_GAIN = 16'h0400
) (
  input wire mclk,
  input wire rst,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire adc_valid,
  input wire adc_offset_conv,
  input wire nv_charge_store,
  input wire nv_param_store
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd_taken = read && !waitrequest;
  a_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request held off longer than one cycle");
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without a request");
  a_offset_ends: assert property (adc_valid && adc_offset_conv |=> !adc_offset_conv)
    else $error("offset slot did not end with its conversion");
  a_offset_cause: assert property ($rose(adc_offset_conv) |-> $past(adc_valid) || $past(write))
    else $error("offset slot began without a cause");
  a_commit_offset: assert property (write && !waitrequest && address == `OFS_CHARGE
    && byteenable[1:0] == 2'b11 |=> adc_offset_conv)
    else $error("charge write did not force an offset conversion");
  a_factory_read: assert property (rd_taken && address == `OFS_FACTORY
    |-> readdata[15:0] == FACTORY_GAIN)
    else $error("factory gain copy read wrong");
  a_unmapped_zero: assert property (rd_taken && address == 8'h20 |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");
  a_store_single: assert property (nv_charge_store |=> !nv_charge_store)
    else $error("charge backup strobe longer than one cycle");
  a_param_store: assert property (nv_param_store |-> $past(write) || $past(write, 2))
    else $error("parameter store without a write");
endmodule
bind coulomb_accumulator coulomb_checker #(.FACTORY_GAIN(FACTORY_GAIN)) checker_i (
  .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .adc_valid(adc_valid), .adc_offset_conv(adc_offset_conv),
  .nv_charge_store(nv_charge_store), .nv_param_store(nv_param_store));

// File: verification/adc_model.sv
`timescale 1ns/1ps
module adc_model #(
  parameter [15:0] OFFSET = 16'h0003
) (
  input wire mclk,
  input wire rst,
  input wire go,
  input wire [1:0] lag,
  input wire [15:0] level,
  input wire adc_offset_conv,
  output reg adc_valid,
  output reg [15:0] adc_sample
);
  reg [2:0] cnt;
  // Sample toggles outside the strobe so stale data is never mistaken for valid
  always @(posedge mclk) begin
    adc_valid <= 1'b0;
    adc_sample <= ~adc_sample;
    if (rst) begin
      cnt <= 3'h0;
      adc_sample <= 16'h0000;
    end else if (go) begin
      cnt <= {1'b0, lag} + 3'h1;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
      if (cnt == 3'h1) begin
        adc_valid <= 1'b1;
        adc_sample <= adc_offset_conv ? OFFSET : level + OFFSET;
      end
    end
  end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "coulomb_regs.vh"
module testbench;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] address = 8'h00;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0000_0000;
  reg [3:0] byteenable = 4'h0;
  reg go = 1'b0;
  reg [1:0] lag = 2'h0;
  reg [15:0] level = 16'h0000;
  reg [15:0] temp = 16'h00c8;
  reg [15:0] s;
  reg [31:0] m;
  wire [31:0] readdata;
  wire waitrequest;
  wire adc_valid;
  wire adc_offset_conv;
  wire [15:0] adc_sample;
  wire nv_charge_store;
  wire [15:0] nv_charge_out;
  wire nv_param_store;
  wire [15:0] nv_gain_out;
  wire [7:0] nv_tc_out;
  integer seed = 82631;
  integer errors = 0;
  integer total_checks = 0;
  integer n_conv = 0;
  integer n_store = 0;
  integer n_param = 0;
  reg [31:0] exp_q[$];
  reg [31:0] msk_q[$];
  always #12.5 mclk = ~mclk;
  // Factory gain value is arbitrary
  coulomb_accumulator #(.ACR_WINDOW_CYCLES(32'h0000_0040), .FACTORY_GAIN(16'h0a5c))
    coulomb_accumulator_i (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .adc_valid(adc_valid), .adc_sample(adc_sample),
    .adc_offset_conv(adc_offset_conv), .temp_value(temp), .nv_charge_in(16'h1234),
    .nv_gain_in(16'h0400), .nv_tc_in(8'h00), .nv_charge_store(nv_charge_store),
    .nv_charge_out(nv_charge_out), .nv_param_store(nv_param_store),
    .nv_gain_out(nv_gain_out), .nv_tc_out(nv_tc_out));
  adc_model adc_model_i (.mclk(mclk), .rst(rst), .go(go), .lag(lag), .level(level),
    .adc_offset_conv(adc_offset_conv), .adc_valid(adc_valid), .adc_sample(adc_sample));
  task check(input [31:0] seen, input [31:0] want);
    total_checks = total_checks + 1;
    if (seen !== want) begin
      errors = errors + 1;
      $display("unexpected value at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  task report_and_stop;
    $display("errors %0d, checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Waitrequest is read at the rising edge, before the slave's own state moves
  task wait_ack;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
  endtask
  task bus_wr(input [7:0] a, input [31:0] d, input [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    wait_ack;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task bus_rd(input [7:0] a, input [31:0] e, input [31:0] mk);
    exp_q.push_back(e);
    msk_q.push_back(mk);
    address <= a;
    byteenable <= 4'hf;
    read <= 1'b1;
    wait_ack;
    read <= 1'b0;
    @(posedge mclk);
  endtask
  task conv(input [15:0] lvl, input integer cnt);
    integer i;
    for (i = 0; i < cnt; i = i + 1) begin
      level <= lvl;
      lag <= 2'($random(seed));
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      while (adc_valid !== 1'b1) @(negedge mclk);
      @(posedge mclk);
    end
  endtask
  always @(posedge mclk) begin
    if (read && !waitrequest && exp_q.size() > 0) begin
      m = msk_q.pop_front();
      check(readdata & m, exp_q.pop_front() & m);
    end
  end
  // Backup strobes, counted against finished conversions, and parameter store strobes, counted against gain and TC writes
  always @(posedge mclk) begin
    if (!rst && adc_valid) n_conv <= n_conv + 1;
    if (nv_charge_store) n_store <= n_store + 1;
    if (nv_param_store) n_param <= n_param + 1;
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    bus_rd(`OFS_BIAS, 32'h0000_0000, 32'h0000_00ff);
    bus_rd(`OFS_FACTORY, 32'h0000_0a5c, 32'h0000_ffff);
    bus_rd(`OFS_CHARGE, 32'h0000_1234, 32'h0000_ffff);
    bus_rd(8'h20, 32'h0000_0000, 32'hffff_ffff);
    bus_wr(`OFS_BIAS, 32'h0000_0005, 4'h1);
    bus_rd(`OFS_BIAS, 32'h0000_0005, 32'h0000_00ff);
    bus_wr(`OFS_GAIN, 32'h0000_0400, 4'h3);
    bus_rd(`OFS_GAIN, 32'h0000_0400, 32'h0000_07ff);
    check(nv_gain_out, 32'h0000_0400);
    bus_wr(`OFS_TC, 32'h0000_0000, 4'h1);
    conv(16'h0000, 1);
    bus_rd(`OFS_CURRENT, 32'h0000_0000, 32'h0000_ffff);
    bus_rd(`OFS_OFFSET, 32'h0000_0003, 32'h0000_ffff);
    s = (16'($random(seed)) & 16'h0fff) | 16'h0400;
    conv(s, 1);
    bus_rd(`OFS_CURRENT, {16'h0000, s + 16'h0005}, 32'h0000_ffff);
    bus_wr(`OFS_BIAS, 32'h0000_00fb, 4'h1);
    conv(s, 1);
    bus_rd(`OFS_CURRENT, {16'h0000, s - 16'h0005}, 32'h0000_ffff);
    bus_wr(`OFS_BIAS, 32'h0000_0000, 4'h1);
    bus_wr(`OFS_CHARGE, 32'h0000_0200, 4'h3);
    conv(16'h0000, 1);
    // A repeat of the last current in the forced offset slot would carry into the integer
    conv(16'h0c10, 1);
    conv(16'h003f, 33);
    bus_rd(`OFS_CHARGE, 32'h0000_0200, 32'h0000_ffff);
    bus_wr(`OFS_CHARGE, 32'h0000_0300, 4'h2);
    bus_wr(`OFS_CHARGE, 32'h0000_0000, 4'h1);
    conv(16'h0000, 1);
    conv(16'h0800, 1);
    bus_rd(`OFS_CHARGE, 32'h0000_0300, 32'h0000_ffff);
    check(nv_charge_out, 32'h0000_0300);
    bus_wr(`OFS_CONTROL, 32'h0000_0001, 4'h1);
    conv(16'hfff1, 137);
    bus_rd(`OFS_CHARGE, 32'h0000_0300, 32'h0000_ffff);
    conv(16'h0800, 1);
    bus_rd(`OFS_CHARGE, 32'h0000_0301, 32'h0000_ffff);
    bus_wr(`OFS_CHARGE, 32'h0000_0500, 4'h2);
    repeat (70) @(posedge mclk);
    bus_wr(`OFS_CHARGE, 32'h0000_0000, 4'h1);
    bus_rd(`OFS_CHARGE, 32'h0000_0301, 32'h0000_ffff);
    bus_wr(`OFS_CHARGE, 32'h0000_0000, 4'h3);
    conv(16'h0000, 1);
    conv(16'hf000, 2);
    bus_rd(`OFS_CHARGE, 32'h0000_0000, 32'h0000_ffff);
    bus_wr(`OFS_CHARGE, 32'h0000_ffff, 4'h3);
    conv(16'h0000, 1);
    conv(16'h7000, 2);
    bus_rd(`OFS_CHARGE, 32'h0000_ffff, 32'h0000_ffff);
    bus_wr(`OFS_CHARGE, 32'h0000_0100, 4'h3);
    conv(16'h0000, 1);
    // A full offset period, so the natural offset slot repeats the last current
    conv(16'h0040, 1023);
    conv(16'h0040, 1);
    bus_rd(`OFS_CHARGE, 32'h0000_0110, 32'h0000_ffff);
    bus_rd(`OFS_CURRENT, 32'h0000_0040, 32'h0000_ffff);
    bus_wr(`OFS_TC, 32'h0000_0040, 4'h1);
    check(nv_tc_out, 32'h0000_0040);
    temp <= 16'h0108;
    conv(16'h0800, 1);
    bus_rd(`OFS_CURRENT, 32'h0000_07e0, 32'h0000_ffff);
    bus_wr(`OFS_TC, 32'h0000_0080, 4'h1);
    conv(16'h0800, 1);
    bus_rd(`OFS_CURRENT, 32'h0000_07e0, 32'h0000_ffff);
    temp <= 16'h010c;
    conv(16'h0800, 1);
    bus_rd(`OFS_CURRENT, 32'h0000_07bc, 32'h0000_ffff);
    check(n_param, 4);
    check(n_store, n_conv / `NV_BACKUP_CONVS);
    bus_wr(`OFS_BIAS, 32'h0000_0011, 4'h1);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    bus_rd(`OFS_BIAS, 32'h0000_0000, 32'h0000_00ff);
    bus_rd(`OFS_CHARGE, 32'h0000_1234, 32'h0000_ffff);
    repeat (2) @(posedge mclk);
    report_and_stop;
  end
  initial begin
    #(25 * 20000);
    errors = errors + 1;
    report_and_stop;
  end
endmodule
